// file: design/gsp_pkg.sv
// Constants, opcodes and field layout for the sector guard control block.
// Function
// R1 - Array-wide protection is chosen only by the status byte one write data.
// R2 - Data bits 5..2 all ones request protection of every sector.
// R3 - Data bits 5..2 all zeros request removal of protection from every sector.
// R4 - A status write loads the lock bit from data bit 7 unless hard-locked; the code also keeps the lock bit when a protect write aborts in a suspend.
// R5 - Pin low, lock clear, field 0000: clear every guard bit; lock takes bit 7.
// R6 - Pin low, lock clear, field 1111: set every guard bit; lock takes bit 7.
// R7 - Lock clear, field 0001 or 1110: guard bits kept, lock takes bit 7.
// R8 - Pin low with lock set: no array-wide change and lock stays set.
// R9 - Array-wide protect during a suspend aborts, keeps guards, clears write enable.
// R10 - Single-sector guard and release commands keep working after array-wide changes.
// R11 - Status or sector commands run only when the write enable latch is set.
// R12 - One guard bit per 64-Kbyte sector, one blocks; all set at power-up.
// R13 - Pin high with lock set: no array-wide change, lock bit may be cleared.
// R14 - Lock clear, pin high: 00h unprotects all, 7Fh protects all, lock stays clear.
// R15 - Any other field value changes no guard bit; lock update still applies.
package gsp_pkg;

	// Sector array geometry.
	localparam int          GSP_NUM_SECT   = 32;
	localparam int          GSP_SECT_W     = 5;

	// Serial command opcodes.
	localparam logic [7:0]  GSP_OP_WREN    = 8'h06;
	localparam logic [7:0]  GSP_OP_WRDI    = 8'h04;
	localparam logic [7:0]  GSP_OP_WRSR    = 8'h01;
	localparam logic [7:0]  GSP_OP_RDSR    = 8'h05;
	localparam logic [7:0]  GSP_OP_PROT    = 8'h36;
	localparam logic [7:0]  GSP_OP_UNPROT  = 8'h39;

	// Whole bytes each command needs before the frame may end, opcode included.
	localparam logic [2:0]  GSP_LEN_SHORT  = 3'h1;
	localparam logic [2:0]  GSP_LEN_WRSR   = 3'h2;
	localparam logic [2:0]  GSP_LEN_SECT   = 3'h4;

	// Status byte one field positions.
	localparam int          GSP_B_LOCK     = 7;
	localparam int          GSP_F_GLB_HI   = 5;
	localparam int          GSP_F_GLB_LO   = 2;
	localparam int          GSP_B_SWP_HI   = 3;
	localparam int          GSP_B_SWP_LO   = 2;
	localparam int          GSP_B_WEL      = 1;
	localparam logic [3:0]  GSP_GLB_UNPROT = 4'h0;
	localparam logic [3:0]  GSP_GLB_PROT   = 4'hf;

	// Summary of the guard bits as shown in the status byte.
	localparam logic [1:0]  GSP_SWP_NONE   = 2'h0;
	localparam logic [1:0]  GSP_SWP_SOME   = 2'h1;
	localparam logic [1:0]  GSP_SWP_ALL    = 2'h3;

	// Reset values.
	localparam logic [31:0] GSP_GUARD_RST  = 32'hffffffff;
	localparam logic        GSP_LOCK_RST   = 1'b0;
	localparam logic        GSP_WEL_RST    = 1'b0;

	// Frame tracking states.
	typedef enum logic [1:0] {
		GSP_ST_IDLE  = 2'b00,
		GSP_ST_SHIFT = 2'b01,
		GSP_ST_EXEC  = 2'b10
	} gsp_state_e;

endpackage : gsp_pkg

// file: design/gsp_guard_ctrl.sv
// Serial command front end and sector guard, lock and write enable logic.
`timescale 1ns/1ps
module gsp_guard_ctrl
	import gsp_pkg::*;
(
	// System clock and reset.
	input  wire logic                    clk_sys,
	input  wire logic                    rstn,
	// Serial pins from the host.
	input  wire logic                    sck,
	input  wire logic                    cs_n,
	input  wire logic                    si,
	input  wire logic                    wp_n,
	// Serial data output pin.
	output logic                         so,
	output logic                         so_oe,
	// Internal suspend indication from the program and erase engine.
	input  wire logic                    suspend_any,
	// Protection state towards the array.
	output logic [GSP_NUM_SECT-1:0]      guard_bits,
	output logic                         guard_regs_lock_bit,
	output logic                         write_enable_latch
);

	// Pin synchronisers, edge history and frame tracking.
	logic                    sck_s1_r, sck_s2_r, sck_d_r;
	logic                    cs_s1_r, cs_s2_r, cs_d_r;
	logic                    si_s1_r, si_s2_r;
	logic                    wp_s1_r, wp_s2_r;
	gsp_state_e              state_r, state_nxt;
	logic [2:0]              bit_cnt_r, bit_cnt_nxt;
	logic [2:0]              byte_cnt_r, byte_cnt_nxt;
	logic [7:0]              shift_r, shift_nxt;
	logic [7:0]              opcode_r, opcode_nxt;
	logic [7:0]              data_r, data_nxt;
	logic [GSP_SECT_W-1:0]   sect_r, sect_nxt;
	logic [GSP_NUM_SECT-1:0] guard_r, guard_nxt;
	logic                    lock_r, lock_nxt;
	logic                    wel_r, wel_nxt;
	logic [7:0]              out_sh_r, out_sh_nxt;
	logic                    so_r, so_nxt;
	logic                    so_oe_r, so_oe_nxt;
	logic                    sck_rise, sck_fall, cs_fall, cs_rise;
	logic [7:0]              shift_in, status_byte;
	logic                    exec, whole_bytes, wrsr_go;
	logic [3:0]              glb_field;

	// Decides whether a completed frame carried at least the bytes a command needs.
	function automatic logic len_ok(input logic [2:0] got, input logic [2:0] need);
		len_ok = (got >= need);
	endfunction : len_ok

	// Every pin passes two flops; the third stage only feeds edge detection.
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			sck_s1_r <= 1'b0;
			sck_s2_r <= 1'b0;
			sck_d_r  <= 1'b0;
			cs_s1_r  <= 1'b1;
			cs_s2_r  <= 1'b1;
			cs_d_r   <= 1'b1;
			si_s1_r  <= 1'b0;
			si_s2_r  <= 1'b0;
			wp_s1_r  <= 1'b1;
			wp_s2_r  <= 1'b1;
		end
		else
		begin
			sck_s1_r <= sck;
			sck_s2_r <= sck_s1_r;
			sck_d_r  <= sck_s2_r;
			cs_s1_r  <= cs_n;
			cs_s2_r  <= cs_s1_r;
			cs_d_r   <= cs_s2_r;
			si_s1_r  <= si;
			si_s2_r  <= si_s1_r;
			wp_s1_r  <= wp_n;
			wp_s2_r  <= wp_s1_r;
		end
	end

	// Edge events seen by the system clock; all pins share the same sync delay.
	assign sck_rise  = sck_s2_r & ~sck_d_r & ~cs_s2_r;
	assign sck_fall  = ~sck_s2_r & sck_d_r & ~cs_s2_r;
	assign cs_fall   = ~cs_s2_r & cs_d_r;
	assign cs_rise   = cs_s2_r & ~cs_d_r;
	assign shift_in  = {shift_r[6:0], si_s2_r};
	assign exec      = (state_r == GSP_ST_EXEC);
	assign whole_bytes = (bit_cnt_r == 3'h0);
	assign glb_field = data_r[GSP_F_GLB_HI:GSP_F_GLB_LO];
	assign wrsr_go   = exec && (opcode_r == GSP_OP_WRSR) && whole_bytes && wel_r
		&& len_ok(byte_cnt_r, GSP_LEN_WRSR);

	// Frame tracking: opcode, first data byte and sector number are captured.
	always_comb
	begin
		state_nxt    = state_r;
		bit_cnt_nxt  = bit_cnt_r;
		byte_cnt_nxt = byte_cnt_r;
		shift_nxt    = shift_r;
		opcode_nxt   = opcode_r;
		data_nxt     = data_r;
		sect_nxt     = sect_r;
		case (state_r)
			GSP_ST_IDLE:
				if (cs_fall)
				begin
					state_nxt    = GSP_ST_SHIFT;
					bit_cnt_nxt  = 3'h0;
					byte_cnt_nxt = 3'h0;
					opcode_nxt   = 8'h00;
				end
			GSP_ST_SHIFT:
				if (cs_rise)
					state_nxt = GSP_ST_EXEC;
				else if (sck_rise)
				begin
					shift_nxt   = shift_in;
					bit_cnt_nxt = bit_cnt_r + 3'h1;
					if (bit_cnt_r == 3'h7)
					begin
						// Count saturates; extra trailing bytes are ignored.
						if (byte_cnt_r != 3'h7)
							byte_cnt_nxt = byte_cnt_r + 3'h1;
						if (byte_cnt_r == 3'h0)
							opcode_nxt = shift_in;
						if (byte_cnt_r == 3'h1)
						begin
							data_nxt = shift_in;
							sect_nxt = shift_in[GSP_SECT_W-1:0];
						end
					end
				end
			GSP_ST_EXEC:
				state_nxt = GSP_ST_IDLE;
			default:
				state_nxt = GSP_ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			state_r    <= GSP_ST_IDLE;
			bit_cnt_r  <= 3'h0;
			byte_cnt_r <= 3'h0;
			shift_r    <= 8'h00;
			opcode_r   <= 8'h00;
			data_r     <= 8'h00;
			sect_r     <= '0;
		end
		else
		begin
			state_r    <= state_nxt;
			bit_cnt_r  <= bit_cnt_nxt;
			byte_cnt_r <= byte_cnt_nxt;
			shift_r    <= shift_nxt;
			opcode_r   <= opcode_nxt;
			data_r     <= data_nxt;
			sect_r     <= sect_nxt;
		end
	end

	// Protection state update, taken one cycle after chip select rises.
	// Everything acts at frame end; an aborted sector command frame still clears the write enable latch, other aborted frames change nothing.
	always_comb
	begin
		guard_nxt = guard_r;
		lock_nxt  = lock_r;
		wel_nxt   = wel_r;
		if (exec)
		begin
			case (opcode_r)
				GSP_OP_WREN:
					if (whole_bytes && len_ok(byte_cnt_r, GSP_LEN_SHORT))
						wel_nxt = 1'b1; // R11
				GSP_OP_WRDI:
					if (whole_bytes && len_ok(byte_cnt_r, GSP_LEN_SHORT))
						wel_nxt = 1'b0;
				GSP_OP_WRSR:
					if (wrsr_go) // R11
					begin
						wel_nxt = 1'b0;
						// Hard lock: guards and lock hold until the pin goes high.
						if (!wp_s2_r && lock_r)
							lock_nxt = 1'b1; // R8
						else if (lock_r)
							lock_nxt = data_r[GSP_B_LOCK]; // R13
						// Suspended sectors must stay open; the write aborts.
						else if (glb_field == GSP_GLB_PROT && suspend_any)
							lock_nxt = lock_r; // R9
						else
						begin
							lock_nxt = data_r[GSP_B_LOCK]; // R4 R7 R15
							if (glb_field == GSP_GLB_UNPROT)
								guard_nxt = '0; // R1 R3 R5 R14
							else if (glb_field == GSP_GLB_PROT)
								guard_nxt = '1; // R1 R2 R6 R14
						end
					end
				GSP_OP_PROT, GSP_OP_UNPROT:
					if (wel_r)
					begin
						wel_nxt = 1'b0;
						if (whole_bytes && len_ok(byte_cnt_r, GSP_LEN_SECT) && !lock_r)
							guard_nxt[sect_r] = (opcode_r == GSP_OP_PROT); // R10
					end
				default:
					wel_nxt = wel_r;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			guard_r <= GSP_GUARD_RST; // R12
			lock_r  <= GSP_LOCK_RST;
			wel_r   <= GSP_WEL_RST;
		end
		else
		begin
			guard_r <= guard_nxt;
			lock_r  <= lock_nxt;
			wel_r   <= wel_nxt;
		end
	end

	// Status byte one as read back with the read status opcode.
	always_comb
	begin
		status_byte                  = 8'h00;
		status_byte[GSP_B_LOCK]      = lock_r;
		status_byte[GSP_B_WEL]       = wel_r;
		if (&guard_r)
			status_byte[GSP_B_SWP_HI:GSP_B_SWP_LO] = GSP_SWP_ALL;
		else if (|guard_r)
			status_byte[GSP_B_SWP_HI:GSP_B_SWP_LO] = GSP_SWP_SOME;
		else
			status_byte[GSP_B_SWP_HI:GSP_B_SWP_LO] = GSP_SWP_NONE;
	end

	// Read status output: reloaded at each byte end, shifted on falling clock.
	// A fresh copy per byte lets a host poll by holding chip select low.
	always_comb
	begin
		out_sh_nxt = out_sh_r;
		so_nxt     = so_r;
		so_oe_nxt  = so_oe_r;
		if (cs_s2_r)
		begin
			so_oe_nxt = 1'b0;
			so_nxt    = 1'b0;
		end
		else if (sck_rise && bit_cnt_r == 3'h7 &&
			((byte_cnt_r == 3'h0 && shift_in == GSP_OP_RDSR) || opcode_r == GSP_OP_RDSR))
		begin
			out_sh_nxt = status_byte;
			so_oe_nxt  = 1'b1;
		end
		else if (sck_fall && so_oe_r)
		begin
			so_nxt     = out_sh_r[7];
			out_sh_nxt = {out_sh_r[6:0], 1'b0};
		end
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			out_sh_r <= 8'h00;
			so_r     <= 1'b0;
			so_oe_r  <= 1'b0;
		end
		else
		begin
			out_sh_r <= out_sh_nxt;
			so_r     <= so_nxt;
			so_oe_r  <= so_oe_nxt;
		end
	end

	// Outputs straight from flops.
	assign so                  = so_r;
	assign so_oe               = so_oe_r;
	assign guard_bits          = guard_r;
	assign guard_regs_lock_bit = lock_r;
	assign write_enable_latch  = wel_r;

	// Checks on the protection state.
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	sequence s_open_wrsr;
		wrsr_go && !lock_r;
	endsequence

	sequence s_pin_low_locked;
		wrsr_go && !wp_s2_r && lock_r;
	endsequence

	a_global_unprot: assert property ((s_open_wrsr and glb_field == GSP_GLB_UNPROT) // R5
		|=> guard_bits == '0)
		else $error("Array-wide unprotect did not clear all guards.");
	a_global_prot: assert property ((s_open_wrsr and // R6
		(glb_field == GSP_GLB_PROT && !suspend_any))
		|=> (&guard_bits) && guard_regs_lock_bit == $past(data_r[GSP_B_LOCK]))
		else $error("Array-wide protect did not set all guards.");
	a_field_nochange: assert property (wrsr_go && glb_field != GSP_GLB_PROT
		&& glb_field != GSP_GLB_UNPROT |=> $stable(guard_bits)) // R7
		else $error("Partial field value changed guards.");
	a_hard_lock: assert property (s_pin_low_locked |=> guard_regs_lock_bit && $stable(guard_bits)) // R8
		else $error("Hard lock did not hold.");
	a_suspend_abort: assert property ((s_open_wrsr and // R9
		(glb_field == GSP_GLB_PROT && suspend_any))
		|=> !write_enable_latch && $stable(guard_bits) && $stable(guard_regs_lock_bit))
		else $error("Protect during suspend did not abort.");
	a_lock_load: assert property ((s_open_wrsr and // R4
		!(glb_field == GSP_GLB_PROT && suspend_any))
		|=> guard_regs_lock_bit == $past(data_r[GSP_B_LOCK]))
		else $error("Lock bit did not take data bit 7.");
	a_soft_lock: assert property (wrsr_go && wp_s2_r && lock_r
		|=> $stable(guard_bits) && guard_regs_lock_bit == $past(data_r[GSP_B_LOCK])) // R13
		else $error("Soft lock handling wrong.");
	a_wel_gate: assert property (exec && !wel_r && opcode_r != GSP_OP_WREN
		|=> $stable(guard_bits) && $stable(guard_regs_lock_bit)) // R11
		else $error("Command ran without write enable.");
	a_sector_cmd: assert property (exec && wel_r && !lock_r && whole_bytes
		&& opcode_r == GSP_OP_UNPROT && byte_cnt_r >= GSP_LEN_SECT
		|=> !guard_bits[$past(sect_r)] && !write_enable_latch) // R10
		else $error("Sector release did not clear its guard.");

endmodule : gsp_guard_ctrl

// file: testbench/gsp_spi_host.sv
// Behavioural serial host that sends command frames to the guard block.
`timescale 1ns/1ps
module gsp_spi_host
(
	// Serial pins towards the device.
	output logic      sck,
	output logic      cs_n,
	output logic      si,
	// Read data from the device.
	input  wire logic so,
	input  wire logic so_oe
);
	localparam realtime HALF = 62.5;

	// The clock is parked low and the select is high between frames.
	initial
	begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end

	// Send nbits of tx MSB first; read bits are taken on each rising clock edge.
	task automatic frame(input logic [31:0] tx, input int nbits, output logic [31:0] rx);
		rx = 32'h0;
		cs_n <= 1'b0;
		for (int i = 0; i < nbits; i++)
		begin
			si <= tx[31-i];
			#(HALF);
			sck <= 1'b1;
			rx = {rx[30:0], so_oe ? so : 1'bx};
			#(HALF);
			sck <= 1'b0;
		end
		#(HALF);
		cs_n <= 1'b1;
		// A released data line must not look as if it still held the last bit.
		si <= ~si;
		#(HALF);
	endtask : frame
endmodule : gsp_spi_host

// file: testbench/global_sector_protect_logic_test.sv
// Self-checking bench for the sector guard control block.
`timescale 1ns/1ps
module global_sector_protect_logic_test
	import gsp_pkg::*;
;
	// Clock, reset and pins.
	logic                    clk_sys;
	logic                    rstn;
	logic                    sck;
	logic                    cs_n;
	logic                    si;
	logic                    wp_n;
	logic                    so;
	logic                    so_oe;
	logic                    suspend_any;
	logic [GSP_NUM_SECT-1:0] guard_bits;
	logic                    guard_regs_lock_bit;
	logic                    write_enable_latch;
	// Reference state and bookkeeping.
	logic [GSP_NUM_SECT-1:0] m_guard;
	logic                    m_lock;
	logic                    m_wel;
	logic [31:0]             rx;
	logic [9:0]              corner [9];
	int                      bad_count;
	int                      compares;
	int                      seed;

	gsp_guard_ctrl i_gsp_guard_ctrl (.clk_sys(clk_sys), .rstn(rstn), .sck(sck), .cs_n(cs_n),
		.si(si), .wp_n(wp_n), .so(so), .so_oe(so_oe), .suspend_any(suspend_any),
		.guard_bits(guard_bits), .guard_regs_lock_bit(guard_regs_lock_bit),
		.write_enable_latch(write_enable_latch));
	gsp_spi_host i_gsp_spi_host (.sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe));

	// System clock.
	always #4 clk_sys = ~clk_sys;

	// Compare one value and count the outcome.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : check

	// Print the counts and the verdict, then stop.
	task automatic final_report();
		$display("compares %0d, mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : final_report

	// Status byte as the reference state predicts it.
	function automatic logic [7:0] exp_status();
		logic [1:0] sum;
		sum = (&m_guard) ? GSP_SWP_ALL : ((|m_guard) ? GSP_SWP_SOME : GSP_SWP_NONE);
		return {m_lock, 3'h0, sum, m_wel, 1'b0};
	endfunction : exp_status

	// One frame, then the outputs against the reference once they have settled.
	task automatic run(input logic [31:0] tx, input int nbits);
		i_gsp_spi_host.frame(tx, nbits, rx);
		repeat (12) @(posedge clk_sys);
		check(guard_bits, m_guard);
		check(32'(guard_regs_lock_bit), 32'(m_lock));
		check(32'(write_enable_latch), 32'(m_wel));
	endtask : run

	task automatic wren();
		m_wel = 1'b1;
		run({GSP_OP_WREN, 24'h0}, 8);
	endtask : wren

	// Status write with the reference decode worked out first.
	task automatic wrsr(input logic [7:0] d);
		logic [3:0] f;
		f = d[GSP_F_GLB_HI:GSP_F_GLB_LO];
		if (m_wel === 1'b1)
		begin
			if (m_lock && !wp_n)
				m_wel = 1'b0;
			else if (m_lock)
			begin
				m_lock = d[GSP_B_LOCK];
				m_wel = 1'b0;
			end
			else
			begin
				m_wel = 1'b0;
				if (!(f == GSP_GLB_PROT && suspend_any))
				begin
					m_lock = d[GSP_B_LOCK];
					if (f == GSP_GLB_UNPROT)
						m_guard = '0;
					if (f == GSP_GLB_PROT)
						m_guard = '1;
				end
			end
		end
		run({GSP_OP_WRSR, d, 16'h0}, 16);
	endtask : wrsr

	// Single-sector guard or release.
	task automatic sect(input logic prot, input logic [4:0] s);
		if (m_wel === 1'b1 && !m_lock)
			m_guard[s] = prot;
		if (m_wel === 1'b1)
			m_wel = 1'b0;
		run({prot ? GSP_OP_PROT : GSP_OP_UNPROT, 3'h0, s, 16'ha55a}, 32);
	endtask : sect

	task automatic rd_status();
		i_gsp_spi_host.frame({GSP_OP_RDSR, 24'h0}, 16, rx);
		repeat (12) @(posedge clk_sys);
		check(32'(rx[7:0]), 32'(exp_status()));
	endtask : rd_status

	// One pass: set pins, enable, status write, a sector command, read back.
	task automatic step(input logic wp, input logic susp, input logic [7:0] d);
		logic [31:0] r;
		@(posedge clk_sys);
		wp_n <= wp;
		suspend_any <= susp;
		wren();
		wrsr(d);
		r = $random(seed);
		wren();
		sect(r[0], r[5:1]);
		rd_status();
	endtask : step

	// Cut a hang short.
	initial
	begin
		#700000;
		bad_count++;
		final_report();
	end

	// Main sequence.
	initial
	begin
		clk_sys = 1'b0;
		rstn = 1'b0;
		wp_n = 1'b1;
		suspend_any = 1'b0;
		m_guard = GSP_GUARD_RST;
		m_lock = GSP_LOCK_RST;
		m_wel = GSP_WEL_RST;
		seed = 32'h233f3d9d;
		// Entries are pin level, suspend, data byte.
		corner = '{10'h200, 10'h27f, 10'h003, 10'h0bc, 10'h000, 10'h20f, 10'h33c,
			10'h284, 10'h278};
		repeat (16) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (4) @(posedge clk_sys);
		rd_status();
		$display("test reset done");
		// Refused frames: no enable, short enable, short status write.
		wrsr(8'h00);
		run({GSP_OP_WREN, 24'h0}, 7);
		wren();
		run({GSP_OP_WRSR, 24'h0}, 15);
		m_wel = 1'b0;
		run({GSP_OP_WRDI, 24'h0}, 8);
		$display("test refusals done");
		foreach (corner[i])
			step(corner[i][9], corner[i][8], corner[i][7:0]);
		$display("test corners done");
		for (int i = 0; i < 30; i++)
		begin
			rx = $random(seed);
			if (rx[0])
				rx[13:10] = rx[14] ? GSP_GLB_PROT : GSP_GLB_UNPROT;
			step(rx[15], rx[17:16] == 2'h3, rx[15:8]);
		end
		$display("test random done");
		final_report();
	end
endmodule : global_sector_protect_logic_test
